// ---- design/tbpwm_defines.vh ----
// register map, field positions and reset values of the timer based pwm channel
`ifndef TBPWM_DEFINES_VH
`define TBPWM_DEFINES_VH

// register bus geometry
`define TBPWM_ADDR_W      3
`define TBPWM_DATA_W      8

// register offsets
`define TBPWM_OFS_CTRL    3'h0
`define TBPWM_OFS_DUTY_HI 3'h1
`define TBPWM_OFS_DUTY_LO 3'h2
`define TBPWM_OFS_TSEL    3'h3

// channel_control_reg fields
`define TBPWM_CTRL_EN     7
`define TBPWM_CTRL_OUT    5
`define TBPWM_CTRL_POL    4

// duty_low_reg field, the two least significant duty bits
`define TBPWM_DCL_MSB     7
`define TBPWM_DCL_LSB     6

// timer_select_reg field
`define TBPWM_TSEL_MSB    1
`define TBPWM_TSEL_LSB    0

// timer_source_field codes
`define TBPWM_SRC_NONE    2'h0
`define TBPWM_SRC_T0      2'h1
`define TBPWM_SRC_T1      2'h2
`define TBPWM_SRC_T2      2'h3

// reset values
`define TBPWM_RST_EN      1'b0
`define TBPWM_RST_POL     1'b0
`define TBPWM_RST_DUTY_HI 8'h00
`define TBPWM_RST_DUTY_LO 2'h0
`define TBPWM_RST_TSEL    2'h1
`define TBPWM_RST_DUTY    10'h000

`endif

// ---- design/tbpwm_src_sel.v ----
// selects the time base of one of the shared 8-bit period timers
`timescale 1ns/100ps
`include "tbpwm_defines.vh"

module tbpwm_src_sel #(
  parameter N_TIMERS = 3
) (
  // selection
  input  wire [1:0]            sel,
  // all timers, timer 0 in the lowest slice
  input  wire [8*N_TIMERS-1:0] cnt_all,
  input  wire [2*N_TIMERS-1:0] pre_all,
  input  wire [N_TIMERS-1:0]   div1_all,
  input  wire [N_TIMERS-1:0]   roll_all,
  // selected timer
  output reg  [7:0]            cnt,
  output reg  [1:0]            pre,
  output reg                   div1,
  output reg                   roll,
  output reg                   valid
);

  // code 00 is reserved and selects no timer at all
  function hit;
    input [1:0] code;
    input integer idx;
    begin
      hit = (code != `TBPWM_SRC_NONE) && ({30'h0, code} == idx + 1);
    end
  endfunction

  integer i;

  always @* begin
    cnt   = 8'h00;
    pre   = 2'h0;
    div1  = 1'b0;
    roll  = 1'b0;
    valid = 1'b0;
    for (i = 0; i < N_TIMERS; i = i + 1) begin
      if (hit(sel, i)) begin
        cnt   = cnt_all[8*i +: 8];
        pre   = pre_all[2*i +: 2];
        div1  = div1_all[i];
        roll  = roll_all[i];
        valid = 1'b1;
      end
    end
  end

endmodule

// ---- design/tbpwm_channel.v ----
// standard pwm channel driven by a selectable shared period timer
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "tbpwm_defines.vh"

// Overview of operation
// - disabled output holds idle level set by polarity
// - period is (period_register+1)*4*tosc*prescale
// - on timer rollover latch duty, drive active unless duty is zero
// - width beyond period leaves output unchanged
// - duty value is high reg plus low bits
// - duty double-buffered, new value at rollover
// - time base is count plus phase/prescaler bits
// - active width is duty times tosc times prescale
// - duty ratio is duty over 4*(period+1)
// - full ten bits when period register is 255
// - sleep freezes state and output level
// - reset returns every register to reset value
// - output timing derives from system clock only
// - enable bit is control bit 7
// - control bit 5 reads live output level
// - polarity bit 4 selects active-low output
// - one of three timers is the time base
// - source codes 01,10,11 pick timers; 00 reserved
module tbpwm_channel #(
  parameter N_TIMERS = 3
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  reset_n,
  // register port
  input  wire [`TBPWM_ADDR_W-1:0] addr,
  input  wire [`TBPWM_DATA_W-1:0] wr_data,
  input  wire                  wr_en,
  input  wire                  rd_en,
  output reg  [`TBPWM_DATA_W-1:0] rd_data,
  // shared timers, timer 0 in the lowest slice
  input  wire [8*N_TIMERS-1:0] timer_count,
  input  wire [2*N_TIMERS-1:0] timer_prescale_bits,
  input  wire [N_TIMERS-1:0]   timer_prescale_one,
  input  wire [N_TIMERS-1:0]   timer_rollover,
  // system clock phase inside one timer increment
  input  wire [1:0]            clock_phase,
  // power state
  input  wire                  sleep,
  // channel output
  output reg                   pwm_out
);

  // output phase states
  localparam [2:0] ST_WAIT = 3'b001;
  localparam [2:0] ST_ON   = 3'b010;
  localparam [2:0] ST_OFF  = 3'b100;

  // software visible registers
  reg                  module_enable_bit;
  reg                  output_polarity_bit;
  reg  [7:0]           duty_high_reg;
  reg  [1:0]           duty_low_bits;
  reg  [1:0]           timer_source_field;

  // duty value actually compared against the time base
  reg  [9:0]           buffered_duty_value;
  reg  [2:0]           state;
  reg  [2:0]           next_state;
  reg  [9:0]           next_duty;
  reg                  next_out;
  reg  [`TBPWM_DATA_W-1:0] next_rd_data;
  reg  [`TBPWM_DATA_W-1:0] read_word;
  reg                  next_enable;
  reg                  next_polarity;
  reg  [7:0]           next_duty_high;
  reg  [1:0]           next_duty_low;
  reg  [1:0]           next_source;

  // selected timer
  wire [7:0]           base_timer_count;
  wire [1:0]           sel_pre;
  wire                 sel_div1;
  wire                 sel_roll;
  wire                 sel_valid;
  wire [1:0]           low_bits;
  wire [9:0]           time_base;
  wire [9:0]           duty_value;
  wire                 pulse_active;
  wire                 reg_wr_ctrl;
  wire                 reg_wr_dch;
  wire                 reg_wr_dcl;
  wire                 reg_wr_tsel;
  wire                 period_start;
  wire                 width_reached;
  wire                 idle_level;
  wire                 active_level;

  // the timer counts and prescales outside; only its state is used here
  tbpwm_src_sel #(
    .N_TIMERS (N_TIMERS)
  ) u_src_sel (
    .sel      (timer_source_field),
    .cnt_all  (timer_count),
    .pre_all  (timer_prescale_bits),
    .div1_all (timer_prescale_one),
    .roll_all (timer_rollover),
    .cnt      (base_timer_count),
    .pre      (sel_pre),
    .div1     (sel_div1),
    .roll     (sel_roll),
    .valid    (sel_valid)
  );

  // register writes

  // one address decode shared by every write strobe
  function reg_hit;
    input [`TBPWM_ADDR_W-1:0] a;
    input [`TBPWM_ADDR_W-1:0] ofs;
    begin
      reg_hit = (a == ofs);
    end
  endfunction

  assign reg_wr_ctrl = wr_en && reg_hit(addr, `TBPWM_OFS_CTRL);
  assign reg_wr_dch  = wr_en && reg_hit(addr, `TBPWM_OFS_DUTY_HI);
  assign reg_wr_dcl  = wr_en && reg_hit(addr, `TBPWM_OFS_DUTY_LO);
  assign reg_wr_tsel = wr_en && reg_hit(addr, `TBPWM_OFS_TSEL);

  // control: enable and polarity; bit 5 is read-only and has no storage
  // a polarity change acts at once, even in mid-pulse
  always @* begin
    next_enable   = module_enable_bit;
    next_polarity = output_polarity_bit;
    if (reg_wr_ctrl) begin
      next_enable   = wr_data[`TBPWM_CTRL_EN];
      next_polarity = wr_data[`TBPWM_CTRL_POL];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      module_enable_bit   <= `TBPWM_RST_EN;
      output_polarity_bit <= `TBPWM_RST_POL;
    end else begin
      module_enable_bit   <= next_enable;
      output_polarity_bit <= next_polarity;
    end
  end

  // duty halves may be written in any order and at any time; neither
  // reaches the comparator before the next period start
  always @* begin
    next_duty_high = duty_high_reg;
    next_duty_low  = duty_low_bits;
    if (reg_wr_dch) begin
      next_duty_high = wr_data;
    end
    if (reg_wr_dcl) begin
      next_duty_low = wr_data[`TBPWM_DCL_MSB:`TBPWM_DCL_LSB];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      duty_high_reg <= `TBPWM_RST_DUTY_HI;
      duty_low_bits <= `TBPWM_RST_DUTY_LO;
    end else begin
      duty_high_reg <= next_duty_high;
      duty_low_bits <= next_duty_low;
    end
  end

  // a reserved source code is kept as written; the channel then sees no
  // rollover and simply waits
  always @* begin
    next_source = timer_source_field;
    if (reg_wr_tsel) begin
      next_source = wr_data[`TBPWM_TSEL_MSB:`TBPWM_TSEL_LSB];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_source_field <= `TBPWM_RST_TSEL;
    end else begin
      timer_source_field <= next_source;
    end
  end

  // left-justified 10-bit duty, high register on top
  assign duty_value = {duty_high_reg, duty_low_bits};

  // register reads, answered in the following cycle

  // word of the addressed register; unmapped addresses and spare bits
  // read as zero
  always @* begin
    read_word = {`TBPWM_DATA_W{1'b0}};
    case (addr)
      `TBPWM_OFS_CTRL: begin
        read_word[`TBPWM_CTRL_EN]  = module_enable_bit;
        read_word[`TBPWM_CTRL_OUT] = pwm_out;
        read_word[`TBPWM_CTRL_POL] = output_polarity_bit;
      end
      `TBPWM_OFS_DUTY_HI: begin
        read_word = duty_high_reg;
      end
      `TBPWM_OFS_DUTY_LO: begin
        read_word[`TBPWM_DCL_MSB:`TBPWM_DCL_LSB] = duty_low_bits;
      end
      `TBPWM_OFS_TSEL: begin
        read_word[`TBPWM_TSEL_MSB:`TBPWM_TSEL_LSB] = timer_source_field;
      end
      default: begin
        read_word = {`TBPWM_DATA_W{1'b0}};
      end
    endcase
  end

  // the port reads zero outside the cycle after a read strobe
  always @* begin
    next_rd_data = {`TBPWM_DATA_W{1'b0}};
    if (rd_en) begin
      next_rd_data = read_word;
    end
  end

  // registered, so the answer stands for the whole following cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= {`TBPWM_DATA_W{1'b0}};
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // time base

  // at 1:1 the timer steps every four system clocks, so the clock phase
  // gives the two extra bits; otherwise the prescaler counter does
  assign low_bits  = sel_div1 ? clock_phase : sel_pre;
  // with the period register at 255 all 1024 steps are reachable
  assign time_base = {base_timer_count, low_bits};

  // output phase machine

  // a period starts on a rollover of a valid source, never in sleep
  assign period_start  = sel_valid && sel_roll && !sleep;
  // a width past the period never matches, so the level stays
  assign width_reached = (time_base == buffered_duty_value);

  always @* begin
    next_state = state;
    if (sleep) begin
      // timer is halted; nothing moves until wake
      next_state = state;
    end else if (period_start) begin
      if (duty_value != 10'h000) begin
        next_state = ST_ON;
      end else begin
        next_state = ST_OFF;
      end
    end else begin
      case (state)
        ST_WAIT: begin
          // no period has started since reset; the output is inactive
          next_state = ST_WAIT;
        end
        ST_ON: begin
          // the pulse ends when the time base reaches the latched width
          if (width_reached) begin
            next_state = ST_OFF;
          end
        end
        ST_OFF: begin
          // the rest of the period stays inactive
          next_state = ST_OFF;
        end
        default: begin
          // an illegal code waits for the next period start
          next_state = ST_WAIT;
        end
      endcase
    end
  end

  // the comparator takes the buffered duty at a period start only, so a
  // write in mid-period never cuts the running pulse short
  always @* begin
    next_duty = buffered_duty_value;
    if (period_start) begin
      next_duty = duty_value;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffered_duty_value <= `TBPWM_RST_DUTY;
    end else begin
      buffered_duty_value <= next_duty;
    end
  end

  // output level

  // the phase machine keeps running while disabled, so enabling mid-period
  // gives a partial first pulse unless the ordered setup is followed
  assign pulse_active = (state == ST_ON);

  // level shown while the channel is off, and the level driven when on
  assign idle_level   = output_polarity_bit;
  assign active_level = pulse_active ^ output_polarity_bit;

  always @* begin
    if (sleep) begin
      // sleep freezes the output at whatever it drives now
      next_out = pwm_out;
    end else if (!module_enable_bit) begin
      next_out = idle_level;
    end else begin
      next_out = active_level;
    end
  end

  // pin direction and routing stay outside; this is only the level
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_out <= `TBPWM_RST_POL;
    end else begin
      pwm_out <= next_out;
    end
  end

endmodule

// ---- dv/tbpwm_props.sv ----
// port assertions of the pwm channel
`timescale 1ns/100ps
module tbpwm_props #(
  parameter N_TIMERS = 3
) (
  // clock and reset
  input wire                clk,
  input wire                reset_n,
  // register port
  input wire [2:0]          addr,
  input wire [7:0]          wr_data,
  input wire                wr_en,
  input wire                rd_en,
  input wire [7:0]          rd_data,
  // timer and power
  input wire [N_TIMERS-1:0] timer_rollover,
  input wire                sleep,
  // output
  input wire                pwm_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // software view kept apart from the design so a broken decode shows up
  logic       en, pol;
  logic [1:0] sel, dl;
  logic [7:0] dh;
  wire  [9:0] duty = {dh, dl};
  wire        roll = (sel != 2'h0) && timer_rollover[sel - 2'h1];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {en, pol, dh, dl} <= 12'h000;
      sel <= 2'h1;
    end else if (wr_en) begin
      if (addr == 3'h0) {en, pol} <= {wr_data[7], wr_data[4]};
      if (addr == 3'h1) dh <= wr_data;
      if (addr == 3'h2) dl <= wr_data[7:6];
      if (addr == 3'h3) sel <= wr_data[1:0];
    end
  end
  a_ctrl_read: assert property ($past(rd_en) && $past(addr) == 3'h0 |->
    rd_data == {$past(en), 1'b0, $past(pwm_out), $past(pol), 4'h0}) else $error("ctrl read");
  a_high_read: assert property ($past(rd_en) && $past(addr) == 3'h1 |->
    rd_data == $past(dh)) else $error("duty high read");
  a_low_read: assert property ($past(rd_en) && $past(addr) == 3'h2 |->
    rd_data == {$past(dl), 6'h00}) else $error("duty low read");
  a_src_read: assert property ($past(rd_en) && $past(addr) == 3'h3 |->
    rd_data == {6'h00, $past(sel)}) else $error("source read");
  a_idle_level: assert property (!$past(en) && !$past(sleep) |->
    pwm_out == $past(pol)) else $error("idle level");
  a_sleep_hold: assert property ($past(sleep) |-> $stable(pwm_out))
    else $error("sleep hold");
  a_pulse_start: assert property (roll && duty > 10'h3 ##0 (en && !pol && !sleep) [*4]
    |-> pwm_out) else $error("pulse start");
  a_zero_duty: assert property (roll && duty == 10'h0 ##0 (en && !pol && !sleep) [*4]
    |-> !pwm_out) else $error("zero duty");
endmodule
bind tbpwm_channel tbpwm_props #(.N_TIMERS(N_TIMERS)) tbpwm_props_inst (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .timer_rollover(timer_rollover), .sleep(sleep),
  .pwm_out(pwm_out));

// ---- dv/tbpwm_timer_model.sv ----
// three shared period timers; timer 1 runs at prescale 1:4, the others 1:1
`timescale 1ns/100ps
module tbpwm_timer_model (
  // clock, reset and power state
  input  wire         clk,
  input  wire         reset_n,
  input  wire         sleep,
  // period registers, timer 0 in the lowest byte
  input  wire  [23:0] period,
  // timer outputs
  output logic [23:0] cnt,
  output logic [5:0]  pre,
  output logic [2:0]  one,
  output logic [2:0]  roll,
  output logic [1:0]  phase
);
  assign one = 3'b101;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {cnt, pre, phase} <= 32'h0;
      roll <= 3'h0;
    end else begin
      // held through sleep like the count, so a pulse due at the edge that
      // enters sleep still reaches the channel after wake
      if (!sleep) begin
        roll <= 3'h0;
        phase <= phase + 2'h1;
        if (phase == 2'h3) begin
          pre[3:2] <= pre[3:2] + 2'h1;
          for (int i = 0; i < 3; i++) begin
            if (i != 1 || pre[3:2] == 2'h3) begin
              if (cnt[8*i +: 8] == period[8*i +: 8]) begin
                cnt[8*i +: 8] <= 8'h00;
                roll[i] <= 1'b1;
              end else begin
                cnt[8*i +: 8] <= cnt[8*i +: 8] + 8'h01;
              end
            end
          end
        end
      end
    end
  end
endmodule

// ---- dv/tbpwm_channel_bench.sv ----
// self-checking bench of the pwm channel with its timer model
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tbpwm_channel_bench;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        sleep = 1'b0;
  logic [23:0] period = 24'h020104;
  logic [7:0]  rd_data;
  logic        pwm_out;
  logic [23:0] cnt;
  logic [5:0]  pre;
  logic [2:0]  one, roll;
  logic [1:0]  phase;
  int          err_total = 0;
  int          check_count = 0;
  always #12.5 clk = ~clk;
  tbpwm_channel tbpwm_channel_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .timer_count(cnt),
    .timer_prescale_bits(pre), .timer_prescale_one(one), .timer_rollover(roll),
    .clock_phase(phase), .sleep(sleep), .pwm_out(pwm_out));
  tbpwm_timer_model tbpwm_timer_model_inst (.clk(clk), .reset_n(reset_n), .sleep(sleep),
    .period(period), .cnt(cnt), .pre(pre), .one(one), .roll(roll), .phase(phase));
  task automatic close_out();
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK("rd_data", e, rd_data)
    @(posedge clk);
  endtask
  // counts cycles at one level; a stuck output ends the run
  task automatic run_while(input logic lv, output int c);
    c = 0;
    while (pwm_out === lv) begin
      @(negedge clk);
      c++;
      if (c > 600) begin
        err_total++;
        close_out();
      end
    end
  endtask
  task automatic meas(input int hi, input int pc);
    int c, h, l;
    run_while(1'b1, c);
    run_while(1'b0, c);
    run_while(1'b1, h);
    run_while(1'b0, l);
    `CHK("high_time", hi, h)
    `CHK("period", pc, h + l)
    @(posedge clk);
  endtask
  task automatic hold(input logic lv, input int n);
    repeat (n) begin
      @(negedge clk);
      `CHK("pwm_out", lv, pwm_out)
    end
    @(posedge clk);
  endtask
  task automatic t_reset();
    rdc(3'h0, 8'h00);
    rdc(3'h1, 8'h00);
    rdc(3'h3, 8'h01);
    hold(1'b0, 2);
  endtask
  task automatic t_regs();
    wr(3'h0, 8'h10);
    wr(3'h2, 8'hff);
    wr(3'h6, 8'hff);
    rdc(3'h2, 8'hc0);
    rdc(3'h6, 8'h00);
    rdc(3'h0, 8'h30);
  endtask
  task automatic t_width();
    int pf[3] = '{1, 4, 1};
    for (int s = 1; s < 4; s++) begin
      wr(3'h3, 8'(s));
      wr(3'h1, 8'h01);
      wr(3'h0, 8'h80);
      meas(7 * pf[s-1], (period[8*(s-1) +: 8] + 1) * 4 * pf[s-1]);
    end
    wr(3'h3, 8'h01);
    wr(3'h0, 8'h90);
    meas(13, 20);
  endtask
  task automatic t_edges();
    wr(3'h0, 8'h80);
    wr(3'h1, 8'hff);
    repeat (45) @(posedge clk);
    hold(1'b1, 60);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    repeat (45) @(posedge clk);
    hold(1'b0, 40);
  endtask
  task automatic t_sleep();
    logic v;
    wr(3'h1, 8'h01);
    wr(3'h2, 8'hc0);
    repeat (47) @(posedge clk);
    sleep <= 1'b1;
    @(negedge clk);
    v = pwm_out;
    hold(v, 30);
    sleep <= 1'b0;
    meas(7, 20);
  endtask
  // reserved source code: no time base, so the level must freeze
  task automatic t_reserved();
    logic v;
    wr(3'h3, 8'h00);
    rdc(3'h3, 8'h00);
    @(negedge clk);
    v = pwm_out;
    hold(v, 40);
    wr(3'h3, 8'h01);
    meas(7, 20);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_width();
    t_edges();
    t_sleep();
    t_reserved();
    close_out();
  end
endmodule
